// file: peiu_checker.sv
// checker for the phy event interrupt unit
// assumes the axi4-lite ports of peiu_top on one clock
module peiu_checker (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic EV_RECEIVE_ERROR,
   input wire logic [3:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY
);
   timeunit 1ns;
   timeprecision 100ps;
   // ---------------------------------
   // read address tracking
   // ---------------------------------
   logic [3:0] raddr_reg;
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) raddr_reg <= 4'h0;
      else if (S_AXI_ARVALID && S_AXI_ARREADY) raddr_reg <= S_AXI_ARADDR;
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);
   sequence s_ar; S_AXI_ARVALID && S_AXI_ARREADY; endsequence
   sequence s_rdstat; s_ar ##0 S_AXI_ARADDR == 4'h4; endsequence
   property p_ar_pulse; S_AXI_ARREADY |=> !S_AXI_ARREADY; endproperty
   a_ar_pulse: assert property (p_ar_pulse) else $error("arready held");
   property p_rv; s_ar |=> S_AXI_RVALID; endproperty
   a_rv: assert property (p_rv) else $error("rvalid late");
   property p_rhold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read answer dropped");
   property p_bhold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID; endproperty
   a_bhold: assert property (p_bhold) else $error("bvalid dropped");
   property p_bv; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID;
   endproperty
   a_bv: assert property (p_bv) else $error("bvalid late");
   property p_zero; S_AXI_RVALID |-> S_AXI_RDATA[4] == 1'b0 && S_AXI_RDATA[31:16] == 16'h0000;
   endproperty
   a_zero: assert property (p_zero) else $error("unused bits set");
   property p_glob; S_AXI_RVALID && raddr_reg == 4'h4 |-> S_AXI_RDATA[15] == |S_AXI_RDATA[14:0];
   endproperty
   a_glob: assert property (p_glob) else $error("global pending wrong");
   property p_rxe; EV_RECEIVE_ERROR ##[2:8] s_rdstat |=> S_AXI_RDATA[0]; endproperty
   a_rxe: assert property (p_rxe) else $error("receive error lost");
endmodule
bind peiu_top peiu_checker peiu_checker_i (.CLK, .RSTN, .EV_RECEIVE_ERROR, .S_AXI_ARADDR,
   .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_AWVALID,
   .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY);

// file: peiu_consts.vh
// constants for the phy event interrupt unit
// assumes a 32-bit axi4-lite slave on a single clock
`ifndef PEIU_CONSTS_VH
`define PEIU_CONSTS_VH
// register byte offsets
`define PEIU_OFF_MASK 4'h0
`define PEIU_OFF_STAT 4'h4
`define PEIU_OFF_AUX 4'h8
`define PEIU_OFF_CTRL 4'hC
// field positions
`define PEIU_BIT_GLOBAL 15
`define PEIU_BIT_SPEED 14
`define PEIU_BIT_LINK 13
`define PEIU_BIT_DUPLEX 12
`define PEIU_BIT_NEGERR 11
`define PEIU_BIT_NEGDONE 10
`define PEIU_BIT_PD 9
`define PEIU_BIT_SYMERR 8
`define PEIU_BIT_FLF 7
`define PEIU_BIT_TXFIFO 6
`define PEIU_BIT_RXFIFO 5
`define PEIU_BIT_FCAR 3
`define PEIU_BIT_DSHIFT 2
`define PEIU_BIT_ROLE 1
`define PEIU_BIT_RXERR 0
`define PEIU_BIT_LPM 6
// control register bits
`define PEIU_CTL_SOFT 0
`define PEIU_CTL_KEEP 1
`define PEIU_CTL_NEG 2
`define PEIU_CTL_PDD 3
// used cause bits: 14..5 and 3..0
`define PEIU_CAUSE_MASK 16'h7FEF
// reset values
`define PEIU_RST_MASK 16'h0000
`define PEIU_RST_STAT 16'h0000
`define PEIU_RST_AUX 16'h0000
`define PEIU_RST_CTRL 4'h4
// axi responses
`define PEIU_RESP_OKAY 2'h0
`define PEIU_RESP_SLVERR 2'h2
`endif

// file: peiu_top.v
// phy event interrupt unit: cause latching, masking and axi4-lite registers
// assumes event inputs are one-cycle pulses synchronous to CLK
// Operation
// R1: mask bit 15 is global enable, reset zero
// R2: enable bits keep value on soft reset if sticky
// R3: unmask bits 14..5, 3..0, reset zero
// R4: status bit 15 set when any cause pending
// R5: status bits clear when status is read
// R6: speed change sets bit 14 if negotiating
// R7: link change or energy sets bit 13
// R8: duplex change sets bit 12 if negotiating
// R9: negotiation error sets bit 11
// R10: negotiation done sets bit 10
// R11: powered device sets bit 9 if detecting
// R12: symbol error sets bit 8
// R13: fast link failure sets bit 7
// R14: transmit fifo fault sets bit 6
// R15: receive fifo fault sets bit 5
// R16: false carrier sets bit 3
// R17: downshift sets bit 2
// R18: role resolution error sets bit 1
// R19: receive error sets bit 0
// R20: aux bit 6 enables energy events, sticky
// R21: irq when enabled and unmasked cause pending
// R22: event during status read stays pending
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`include "peiu_consts.vh"
module peiu_top (
   input wire CLK,
   input wire RSTN,
   input wire EV_SPEED_CHANGE,
   input wire EV_LINK_CHANGE,
   input wire EV_ENERGY_DETECT,
   input wire EV_DUPLEX_CHANGE,
   input wire EV_NEG_ERROR,
   input wire EV_NEG_DONE,
   input wire EV_POWERED_DEVICE,
   input wire EV_SYMBOL_ERROR,
   input wire EV_FAST_LINKFAIL,
   input wire EV_TX_FIFO_FAULT,
   input wire EV_RX_FIFO_FAULT,
   input wire EV_FALSE_CARRIER,
   input wire EV_DOWNSHIFT,
   input wire EV_ROLE_ERROR,
   input wire EV_RECEIVE_ERROR,
   output reg IRQ,
   input wire [3:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   output reg S_AXI_AWREADY,
   input wire [31:0] S_AXI_WDATA,
   input wire [3:0] S_AXI_WSTRB,
   input wire S_AXI_WVALID,
   output reg S_AXI_WREADY,
   output reg [1:0] S_AXI_BRESP,
   output reg S_AXI_BVALID,
   input wire S_AXI_BREADY,
   input wire [3:0] S_AXI_ARADDR,
   input wire S_AXI_ARVALID,
   output reg S_AXI_ARREADY,
   output reg [31:0] S_AXI_RDATA,
   output reg [1:0] S_AXI_RRESP,
   output reg S_AXI_RVALID,
   input wire S_AXI_RREADY
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg [15:0] mask_reg;
   reg [15:0] stat_reg;
   reg [15:0] aux_reg;
   reg [3:0] ctrl_reg;
   reg [3:0] awaddr_reg;
   reg [31:0] wdata_reg;
   reg [3:0] wstrb_reg;
   reg aw_have_reg;
   reg w_have_reg;
   reg [15:0] stat_next;
   reg [15:0] cause;
   wire wr_fire;
   wire rd_fire;
   wire soft_rst;
   wire keep;
   wire stat_read;
   wire global_irq_enable;
   wire negotiation_enable;
   wire powered_device_detect_enable;
   wire link_power_mgmt_enable;

   // byte-lane merge of a 16-bit register
   function [15:0] merge16;
      input [15:0] old;
      input [31:0] data;
      input [3:0] strb;
      begin
         merge16 = old;
         if (strb[0]) begin
            merge16[7:0] = data[7:0];
         end
         if (strb[1]) begin
            merge16[15:8] = data[15:8];
         end
      end
   endfunction

   assign global_irq_enable = mask_reg[`PEIU_BIT_GLOBAL];
   assign negotiation_enable = ctrl_reg[`PEIU_CTL_NEG];
   assign powered_device_detect_enable = ctrl_reg[`PEIU_CTL_PDD];
   assign link_power_mgmt_enable = aux_reg[`PEIU_BIT_LPM];
   assign keep = ctrl_reg[`PEIU_CTL_KEEP];
   assign wr_fire = aw_have_reg && w_have_reg && !S_AXI_BVALID;
   assign rd_fire = S_AXI_ARVALID && S_AXI_ARREADY;
   assign soft_rst = wr_fire && (awaddr_reg[3:2] == `PEIU_OFF_CTRL >> 2)
      && wstrb_reg[0] && wdata_reg[`PEIU_CTL_SOFT];
   assign stat_read = rd_fire && (S_AXI_ARADDR[3:2] == `PEIU_OFF_STAT >> 2);

   // ----------------------------------------
   // cause collection
   // ----------------------------------------
   always @* begin
      cause = 16'h0000;
      cause[`PEIU_BIT_SPEED] = EV_SPEED_CHANGE && negotiation_enable; // R6
      cause[`PEIU_BIT_LINK] = EV_LINK_CHANGE
         || (EV_ENERGY_DETECT && link_power_mgmt_enable); // R7
      cause[`PEIU_BIT_DUPLEX] = EV_DUPLEX_CHANGE && negotiation_enable; // R8
      cause[`PEIU_BIT_NEGERR] = EV_NEG_ERROR; // R9
      cause[`PEIU_BIT_NEGDONE] = EV_NEG_DONE; // R10
      cause[`PEIU_BIT_PD] = EV_POWERED_DEVICE && powered_device_detect_enable; // R11
      cause[`PEIU_BIT_SYMERR] = EV_SYMBOL_ERROR; // R12
      cause[`PEIU_BIT_FLF] = EV_FAST_LINKFAIL; // R13
      cause[`PEIU_BIT_TXFIFO] = EV_TX_FIFO_FAULT; // R14
      cause[`PEIU_BIT_RXFIFO] = EV_RX_FIFO_FAULT; // R15
      cause[`PEIU_BIT_FCAR] = EV_FALSE_CARRIER; // R16
      cause[`PEIU_BIT_DSHIFT] = EV_DOWNSHIFT; // R17
      cause[`PEIU_BIT_ROLE] = EV_ROLE_ERROR; // R18
      cause[`PEIU_BIT_RXERR] = EV_RECEIVE_ERROR; // R19
   end

   // ----------------------------------------
   // pending status
   // ----------------------------------------
   always @* begin
      stat_next = stat_reg & `PEIU_CAUSE_MASK;
      if (stat_read) begin
         stat_next = 16'h0000; // R5
      end
      stat_next = stat_next | cause; // R22
      stat_next[`PEIU_BIT_GLOBAL] = |(stat_next & `PEIU_CAUSE_MASK); // R4
   end

   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         stat_reg <= `PEIU_RST_STAT;
      end else if (soft_rst) begin
         stat_reg <= cause | {|cause, 15'h0000};
      end else begin
         stat_reg <= stat_next;
      end
   end

   // ----------------------------------------
   // mask, aux and control registers
   // ----------------------------------------
   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         mask_reg <= `PEIU_RST_MASK; // R1 R3
         aux_reg <= `PEIU_RST_AUX;
         ctrl_reg <= `PEIU_RST_CTRL;
      end else begin
         if (soft_rst && !keep) begin
            mask_reg <= `PEIU_RST_MASK; // R2
            aux_reg <= `PEIU_RST_AUX; // R20
         end else if (wr_fire && awaddr_reg[3:2] == `PEIU_OFF_MASK >> 2) begin
            mask_reg <= merge16(mask_reg, wdata_reg, wstrb_reg)
               & (`PEIU_CAUSE_MASK | 16'h8000); // R1 R3 R21
         end else if (wr_fire && awaddr_reg[3:2] == `PEIU_OFF_AUX >> 2) begin
            aux_reg <= merge16(aux_reg, wdata_reg, wstrb_reg)
               & 16'h0040; // R20
         end
         if (wr_fire && awaddr_reg[3:2] == `PEIU_OFF_CTRL >> 2 && wstrb_reg[0]) begin
            ctrl_reg <= {wdata_reg[3:1], 1'b0};
         end
      end
   end

   // ----------------------------------------
   // interrupt output
   // ----------------------------------------
   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= global_irq_enable
            && |(stat_reg & mask_reg & `PEIU_CAUSE_MASK); // R21 R1
      end
   end

   // ----------------------------------------
   // axi4-lite write channel
   // ----------------------------------------
   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         awaddr_reg <= 4'h0;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY <= 1'b0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= `PEIU_RESP_OKAY;
      end else begin
         S_AXI_AWREADY <= !aw_have_reg && !S_AXI_AWREADY && !S_AXI_BVALID;
         S_AXI_WREADY <= !w_have_reg && !S_AXI_WREADY && !S_AXI_BVALID;
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_have_reg <= 1'b1;
            awaddr_reg <= S_AXI_AWADDR;
            S_AXI_AWREADY <= 1'b0;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_have_reg <= 1'b1;
            wdata_reg <= S_AXI_WDATA;
            wstrb_reg <= S_AXI_WSTRB;
            S_AXI_WREADY <= 1'b0;
         end
         if (wr_fire) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= (awaddr_reg[3:2] == `PEIU_OFF_STAT >> 2)
               ? `PEIU_RESP_SLVERR : `PEIU_RESP_OKAY;
         end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // axi4-lite read channel
   // ----------------------------------------
   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h00000000;
         S_AXI_RRESP <= `PEIU_RESP_OKAY;
      end else begin
         S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
         if (rd_fire) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP <= `PEIU_RESP_OKAY;
            case (S_AXI_ARADDR[3:2])
               2'h0: S_AXI_RDATA <= {16'h0000, mask_reg};
               2'h1: S_AXI_RDATA <= {16'h0000, stat_reg}; // R5
               2'h2: S_AXI_RDATA <= {16'h0000, aux_reg};
               2'h3: S_AXI_RDATA <= {28'h0000000, ctrl_reg};
               default: S_AXI_RDATA <= 32'h00000000;
            endcase
         end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
         end
      end
   end
endmodule

// file: peiu_top_tb_top.sv
// testbench for the phy event interrupt unit
// assumes peiu_top with offsets mask 0, status 4, aux 8, control C
`include "peiu_consts.vh"
module peiu_top_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   // ---------------------------------
   // stimulus and checking
   // ---------------------------------
   logic clk = 0, rstn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, egy = 0;
   logic irq, awr, wrdy, bv, arr, rv;
   logic [3:0] aw = 4'h0, ar = 4'h0;
   logic [31:0] wd = 32'h0, d, rdata;
   logic [15:0] ev = 16'h0;
   logic [1:0] r, bresp, rresp;
   int errors = 0, comparisons = 0, k;
   peiu_top peiu_top_i (.CLK(clk), .RSTN(rstn), .EV_SPEED_CHANGE(ev[14]),
      .EV_LINK_CHANGE(ev[13]), .EV_ENERGY_DETECT(egy), .EV_DUPLEX_CHANGE(ev[12]),
      .EV_NEG_ERROR(ev[11]), .EV_NEG_DONE(ev[10]), .EV_POWERED_DEVICE(ev[9]),
      .EV_SYMBOL_ERROR(ev[8]), .EV_FAST_LINKFAIL(ev[7]), .EV_TX_FIFO_FAULT(ev[6]),
      .EV_RX_FIFO_FAULT(ev[5]), .EV_FALSE_CARRIER(ev[3]), .EV_DOWNSHIFT(ev[2]),
      .EV_ROLE_ERROR(ev[1]), .EV_RECEIVE_ERROR(ev[0]), .IRQ(irq), .S_AXI_AWADDR(aw),
      .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
      .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
      .S_AXI_BREADY(br), .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr));
   initial begin
      forever #12.5 clk = ~clk;
   end
   task conclude;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task put(input logic [3:0] a, input logic [31:0] v, output logic [1:0] o);
      int i;
      @(posedge clk);
      aw <= a; wd <= v; awv <= 1'b1; wv <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(posedge clk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wrdy) wv <= 1'b0;
         if (bv && br) begin
            o = bresp; br <= 1'b0; break;
         end
         if (bv) br <= 1'b1;
      end
      if (i == 40) begin errors++; conclude; end
   endtask
   task get(input logic [3:0] a, output logic [31:0] o);
      int i;
      @(posedge clk);
      ar <= a; arv <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(posedge clk);
         if (arv && arr) arv <= 1'b0;
         if (rv && rr) begin
            o = rdata; rr <= 1'b0; break;
         end
         if (rv) rr <= 1'b1;
      end
      if (i == 40) begin errors++; conclude; end
   endtask
   task fire(input logic [15:0] v, input logic en);
      @(posedge clk);
      ev <= v; egy <= en;
      @(posedge clk);
      ev <= 16'h0; egy <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      get(4'h0, d); chk("mask", d, 32'h0);
      get(4'h4, d); chk("stat", d, 32'h0);
      put(4'h0, 32'hFFFFFFFF, r); chk("okay", {30'h0, r}, {30'h0, `PEIU_RESP_OKAY});
      get(4'h0, d); chk("mask", d, 32'hFFEF);
      put(4'h4, 32'hFFFF, r); chk("resp", {30'h0, r}, {30'h0, `PEIU_RESP_SLVERR});
      put(4'hC, 32'hE, r);
      put(4'h8, 32'h40, r);
      for (k = 0; k < 15; k++) if (k != 4) begin
         fire(16'h1 << k, 1'b0);
         chk("irq", {31'h0, irq}, 32'h1);
         get(4'h4, d);
         chk("cause", d, 32'h8000 | (32'h1 << k));
         get(4'h4, d); chk("cleared", d, 32'h0);
      end
      fire(16'h0, 1'b1); get(4'h4, d); chk("energy", d, 32'hA000);
      put(4'hC, 32'hF, r); get(4'h0, d); chk("kept", d, 32'hFFEF);
      get(4'h8, d); chk("aux", d, 32'h40);
      put(4'hC, 32'h0, r);
      put(4'hC, 32'h1, r); get(4'h0, d); chk("lost", d, 32'h0);
      get(4'h8, d); chk("aux", d, 32'h0);
      fire(16'h5200, 1'b1); get(4'h4, d); chk("gated", d, 32'h0);
      put(4'h0, 32'h7FEF, r); fire(16'h1, 1'b0);
      chk("irq", {31'h0, irq}, 32'h0);
      get(4'h4, d); chk("stat", d, 32'h8001);
      conclude;
   end
endmodule
